/* twras_cfg.svh */
// Constants of the two-wire register access slave and its master
// Operation
// - Slave only, seven-bit address 0101110 plus direction
// - Works at 100 kbps and 400 kbps
// - Clock input only, data pulled low open-drain
// - Eight-bit bytes, one bit per clock, MSB first
// - Receiver of a byte returns an acknowledge bit
// - Master starts, clocks and stops every transfer
// - Data changes only while clock is low
// - Data fall while clock high starts, rise stops
// - Slave pulls data low to acknowledge accepted bytes
// - Master releases data during slave acknowledge
// - Unaccepted byte leaves data released: not-acknowledge
// - Master stops after a slave not-acknowledge
// - Register access one byte, FIFO access several
// - Write: address+0, ack, index, ack, data, ack, stop
// - Slave acknowledges further FIFO write bytes
// - Read: write index, repeated start, address+1, data
// - Master not-acknowledges final read byte, then stops
// - Slave sends while acked; last byte not acked
`ifndef TWRAS_CFG_SVH
`define TWRAS_CFG_SVH

// Fixed bus address of the slave
`define TWRAS_DEV_ADDR    7'h2e
// Direction bit values
`define TWRAS_DIR_WR      1'b0
`define TWRAS_DIR_RD      1'b1
// Bit positions of the acknowledge slot and the byte
`define TWRAS_ACK_BIT     4'h8
`define TWRAS_MSB         7
// Serial clock rates in Hz
`define TWRAS_SCL_STD_HZ  100000
`define TWRAS_SCL_FAST_HZ 400000
// Master clock rate in Hz
`define TWRAS_MCLK_HZ     100000000

`endif

/* twras_pkg.sv */
// Types shared by both ends of the two-wire link
package twras_pkg;

	// Slave states
	typedef enum logic [5:0] {
		TWRAS_S_IDLE  = 6'h01,
		TWRAS_S_ADDR  = 6'h02,
		TWRAS_S_SUB   = 6'h04,
		TWRAS_S_WDATA = 6'h08,
		TWRAS_S_RDATA = 6'h10,
		TWRAS_S_SKIP  = 6'h20
	} twras_slv_e;

	// Master states
	typedef enum logic [3:0] {
		TWRAS_M_IDLE  = 4'h1,
		TWRAS_M_START = 4'h2,
		TWRAS_M_BYTE  = 4'h4,
		TWRAS_M_STOP  = 4'h8
	} twras_mst_e;

	// Role of the byte the master is moving
	typedef enum logic [3:0] {
		TWRAS_R_ADDRW = 4'h1,
		TWRAS_R_SUB   = 4'h2,
		TWRAS_R_ADDRR = 4'h4,
		TWRAS_R_DATA  = 4'h8
	} twras_role_e;

endpackage : twras_pkg

/* twras_if.sv */
// Two-wire bus between master and slave with the wired data line
interface twras_if;

	logic scl;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic sda;

	// Open-drain data line with pull-up: low while any driver pulls low
	assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

	modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
	modport slave  (input scl, input sda, output s_sda_o, output s_sda_oe);

endinterface : twras_if

/* twras_sync.sv */
// Two flip-flop synchroniser for bus pin levels
module twras_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	// Levels
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	logic [W-1:0] meta_reg;

	// First stage feeds only the second; pins idle high
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			meta_reg <= '1;
			o_q      <= '1;
		end else begin
			meta_reg <= i_d;
			o_q      <= meta_reg;
		end
	end

endmodule : twras_sync

/* twras_slave.sv */
// Slave end: serial register and FIFO access port on the link clock
`include "twras_cfg.svh"
module twras_slave (
	// Link clock and reset
	input  wire logic       i_lclk,
	input  wire logic       i_rstn,
	// Two-wire bus
	twras_if.slave          bus,
	// Register and FIFO write side
	output logic      [7:0] o_addr,
	output logic            o_wr_stb,
	output logic      [7:0] o_wr_data,
	input  wire logic       i_wr_ready,
	input  wire logic       i_addr_fifo,
	// Register and FIFO read side
	output logic            o_rd_stb,
	input  wire logic [7:0] i_rd_data,
	// Status
	output logic            o_busy
);

	twras_pkg::twras_slv_e state_reg;
	twras_pkg::twras_slv_e state_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [3:0] bitcnt_reg;
	logic [3:0] bitcnt_next;
	logic       ack_ph_reg;
	logic       ack_ph_next;
	logic       sda_low_reg;
	logic       sda_low_next;
	logic       rw_reg;
	logic       rw_next;
	logic       first_reg;
	logic       first_next;
	logic [7:0] addr_reg;
	logic [7:0] addr_next;
	logic       wr_stb_reg;
	logic       wr_stb_next;
	logic [7:0] wr_data_reg;
	logic [7:0] wr_data_next;
	logic       rd_stb_reg;
	logic       rd_stb_next;
	logic       scl_d_reg;
	logic       sda_d_reg;

	logic       scl_s;
	logic       sda_s;

	// Bus pins cross into the link clock domain
	twras_sync #(.W(2)) u_sync (
		.i_clk  (i_lclk),
		.i_rstn (i_rstn),
		.i_d    ({bus.scl, bus.sda}),
		.o_q    ({scl_s, sda_s})
	);

	// Edge and condition detection on the synchronised pins
	wire scl_rise  = scl_s & ~scl_d_reg;
	wire scl_fall  = ~scl_s & scl_d_reg;
	wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	// Acceptance of the byte just received
	wire addr_hit = (shift_reg[7:1] == `TWRAS_DEV_ADDR);
	wire wd_ok    = i_wr_ready & (first_reg | i_addr_fifo);
	wire accept   = (state_reg == twras_pkg::TWRAS_S_ADDR) ? addr_hit :
	                (state_reg == twras_pkg::TWRAS_S_SUB)  ? 1'b1 :
	                wd_ok;
	wire byte_in  = (bitcnt_reg == `TWRAS_ACK_BIT);

	// Next-state logic of the byte engine
	always_comb begin
		state_next   = state_reg;
		shift_next   = shift_reg;
		bitcnt_next  = bitcnt_reg;
		ack_ph_next  = ack_ph_reg;
		sda_low_next = sda_low_reg;
		rw_next      = rw_reg;
		first_next   = first_reg;
		addr_next    = addr_reg;
		wr_stb_next  = 1'b0;
		wr_data_next = wr_data_reg;
		rd_stb_next  = 1'b0;
		if (start_det) begin
			// Start or repeated start always re-arms address match
			state_next   = twras_pkg::TWRAS_S_ADDR;
			bitcnt_next  = 4'h0;
			ack_ph_next  = 1'b0;
			sda_low_next = 1'b0;
		end else if (stop_det) begin
			state_next   = twras_pkg::TWRAS_S_IDLE;
			bitcnt_next  = 4'h0;
			ack_ph_next  = 1'b0;
			sda_low_next = 1'b0;
		end else begin
			case (state_reg)
			twras_pkg::TWRAS_S_ADDR,
			twras_pkg::TWRAS_S_SUB,
			twras_pkg::TWRAS_S_WDATA: begin
				if (scl_rise && !ack_ph_reg && !byte_in) begin
					// Sample while clock is high, MSB first
					shift_next  = {shift_reg[6:0], sda_s};
					bitcnt_next = bitcnt_reg + 4'h1;
				end else if (scl_fall && !ack_ph_reg && byte_in) begin
					// Ninth clock: pull low only for an accepted byte
					ack_ph_next  = 1'b1;
					sda_low_next = accept;
					if (accept) begin
						if (state_reg == twras_pkg::TWRAS_S_ADDR) begin
							rw_next = shift_reg[0];
						end else if (state_reg == twras_pkg::TWRAS_S_SUB) begin
							addr_next  = shift_reg;
							first_next = 1'b1;
						end else begin
							wr_stb_next  = 1'b1;
							wr_data_next = shift_reg;
							first_next   = 1'b0;
						end
					end
				end else if (scl_fall && ack_ph_reg) begin
					// Acknowledge clock over: release and move on
					ack_ph_next  = 1'b0;
					bitcnt_next  = 4'h0;
					sda_low_next = 1'b0;
					if (!sda_low_reg) begin
						state_next = twras_pkg::TWRAS_S_SKIP;
					end else if (state_reg == twras_pkg::TWRAS_S_ADDR) begin
						if (rw_reg == `TWRAS_DIR_RD) begin
							// First read byte goes out right away
							state_next   = twras_pkg::TWRAS_S_RDATA;
							rd_stb_next  = 1'b1;
							shift_next   = i_rd_data;
							sda_low_next = ~i_rd_data[`TWRAS_MSB];
							bitcnt_next  = 4'h1;
						end else begin
							state_next = twras_pkg::TWRAS_S_SUB;
						end
					end else begin
						state_next = twras_pkg::TWRAS_S_WDATA;
					end
				end
			end
			twras_pkg::TWRAS_S_RDATA: begin
				if (ack_ph_reg) begin
					if (scl_rise && sda_s) begin
						// Master not-acknowledge ends the read
						state_next  = twras_pkg::TWRAS_S_SKIP;
						ack_ph_next = 1'b0;
					end else if (scl_fall) begin
						// Acknowledged: send the next byte
						ack_ph_next  = 1'b0;
						rd_stb_next  = 1'b1;
						shift_next   = i_rd_data;
						sda_low_next = ~i_rd_data[`TWRAS_MSB];
						bitcnt_next  = 4'h1;
					end
				end else if (scl_fall) begin
					if (!byte_in) begin
						// Next bit only while clock is low
						shift_next   = {shift_reg[6:0], 1'b0};
						sda_low_next = ~shift_reg[`TWRAS_MSB-1];
						bitcnt_next  = bitcnt_reg + 4'h1;
					end else begin
						// Release for the master's acknowledge
						ack_ph_next  = 1'b1;
						sda_low_next = 1'b0;
					end
				end
			end
			default: begin
				// Idle, or ignoring traffic until the next start
			end
			endcase
		end
	end

	// State registers
	always_ff @(posedge i_lclk) begin
		if (!i_rstn) begin
			state_reg   <= twras_pkg::TWRAS_S_IDLE;
			shift_reg   <= 8'h00;
			bitcnt_reg  <= 4'h0;
			ack_ph_reg  <= 1'b0;
			sda_low_reg <= 1'b0;
			rw_reg      <= 1'b0;
			first_reg   <= 1'b0;
			addr_reg    <= 8'h00;
			wr_stb_reg  <= 1'b0;
			wr_data_reg <= 8'h00;
			rd_stb_reg  <= 1'b0;
		end else begin
			state_reg   <= state_next;
			shift_reg   <= shift_next;
			bitcnt_reg  <= bitcnt_next;
			ack_ph_reg  <= ack_ph_next;
			sda_low_reg <= sda_low_next;
			rw_reg      <= rw_next;
			first_reg   <= first_next;
			addr_reg    <= addr_next;
			wr_stb_reg  <= wr_stb_next;
			wr_data_reg <= wr_data_next;
			rd_stb_reg  <= rd_stb_next;
		end
	end

	// Delayed pin copies for edge detection
	always_ff @(posedge i_lclk) begin
		if (!i_rstn) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// Open-drain data pull, never a high drive
	assign bus.s_sda_o  = 1'b0;
	assign bus.s_sda_oe = sda_low_reg;

	// User side outputs
	assign o_addr    = addr_reg;
	assign o_wr_stb  = wr_stb_reg;
	assign o_wr_data = wr_data_reg;
	assign o_rd_stb  = rd_stb_reg;
	assign o_busy    = (state_reg != twras_pkg::TWRAS_S_IDLE);

endmodule : twras_slave

/* twras_master.sv */
// Master end: drives the serial clock and runs write and read transfers
`include "twras_cfg.svh"
module twras_master #(
	parameter int MCLK_HZ = `TWRAS_MCLK_HZ,
	parameter int SCL_HZ  = `TWRAS_SCL_STD_HZ
) (
	// Clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rstn,
	// Two-wire bus
	twras_if.master         bus,
	// Command
	input  wire logic       i_go,
	input  wire logic       i_rw,
	input  wire logic [7:0] i_sub,
	input  wire logic [3:0] i_count,
	input  wire logic [7:0] i_wdata,
	output logic            o_wdata_take,
	// Results
	output logic      [7:0] o_rdata,
	output logic            o_rdata_vld,
	output logic            o_busy,
	output logic            o_done,
	output logic            o_nack
);

	// Quarter of a serial clock period, rounded up
	localparam int QTR_CYC = (MCLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
	localparam logic [15:0] QTR_LAST = 16'(QTR_CYC - 1);

	twras_pkg::twras_mst_e  state_reg;
	twras_pkg::twras_role_e role_reg;
	logic [15:0] qcnt_reg;
	logic [1:0]  ph_reg;
	logic [3:0]  bit_reg;
	logic [7:0]  shift_reg;
	logic [3:0]  left_reg;
	logic        rw_reg;
	logic [7:0]  sub_reg;
	logic        scl_reg;
	logic        sda_low_reg;
	logic        nack_reg;
	logic [7:0]  rdata_reg;
	logic        rvld_reg;
	logic        take_reg;
	logic        done_reg;
	logic        sda_s;

	// Data pin into the master clock domain
	twras_sync #(.W(1)) u_sync (
		.i_clk  (i_mclk),
		.i_rstn (i_rstn),
		.i_d    (bus.sda),
		.o_q    (sda_s)
	);

	// Phase and byte decoding
	wire tick    = (qcnt_reg == QTR_LAST);
	wire rd_data = (role_reg == twras_pkg::TWRAS_R_DATA) & rw_reg;
	wire last_bt = (left_reg == 4'h1);
	wire ack_bit = (bit_reg == `TWRAS_ACK_BIT);

	// Byte to shift out for a given role
	function automatic logic [7:0] load_byte(twras_pkg::twras_role_e r,
	                                         logic [7:0] sub,
	                                         logic [7:0] wd,
	                                         logic rw);
		if (r == twras_pkg::TWRAS_R_ADDRW) begin
			load_byte = {`TWRAS_DEV_ADDR, `TWRAS_DIR_WR};
		end else if (r == twras_pkg::TWRAS_R_ADDRR) begin
			load_byte = {`TWRAS_DEV_ADDR, `TWRAS_DIR_RD};
		end else if (r == twras_pkg::TWRAS_R_SUB) begin
			load_byte = sub;
		end else begin
			load_byte = rw ? 8'hff : wd;
		end
	endfunction : load_byte

	// Quarter-period divider, free running while busy
	always_ff @(posedge i_mclk) begin
		if (!i_rstn || state_reg == twras_pkg::TWRAS_M_IDLE || tick) begin
			qcnt_reg <= 16'h0000;
		end else begin
			qcnt_reg <= qcnt_reg + 16'h0001;
		end
	end

	// Transfer sequencer
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			state_reg   <= twras_pkg::TWRAS_M_IDLE;
			role_reg    <= twras_pkg::TWRAS_R_ADDRW;
			ph_reg      <= 2'h0;
			bit_reg     <= 4'h0;
			shift_reg   <= 8'h00;
			left_reg    <= 4'h0;
			rw_reg      <= 1'b0;
			sub_reg     <= 8'h00;
			scl_reg     <= 1'b1;
			sda_low_reg <= 1'b0;
			nack_reg    <= 1'b0;
			rdata_reg   <= 8'h00;
			rvld_reg    <= 1'b0;
			take_reg    <= 1'b0;
			done_reg    <= 1'b0;
		end else begin
			rvld_reg <= 1'b0;
			take_reg <= 1'b0;
			done_reg <= 1'b0;
			if (tick) begin
				ph_reg <= ph_reg + 2'h1;
			end
			case (state_reg)
			twras_pkg::TWRAS_M_IDLE: begin
				ph_reg <= 2'h0;
				if (i_go) begin
					state_reg <= twras_pkg::TWRAS_M_START;
					role_reg  <= twras_pkg::TWRAS_R_ADDRW;
					rw_reg    <= i_rw;
					sub_reg   <= i_sub;
					left_reg  <= i_count;
					nack_reg  <= 1'b0;
				end
			end
			twras_pkg::TWRAS_M_START: begin
				if (tick) begin
					if (ph_reg == 2'h0) begin
						sda_low_reg <= 1'b0;
					end else if (ph_reg == 2'h1) begin
						scl_reg <= 1'b1;
					end else if (ph_reg == 2'h2) begin
						sda_low_reg <= 1'b1;
					end else begin
						scl_reg   <= 1'b0;
						state_reg <= twras_pkg::TWRAS_M_BYTE;
						bit_reg   <= 4'h0;
						shift_reg <= load_byte(role_reg, sub_reg, i_wdata,
						                       rw_reg);
					end
				end
			end
			twras_pkg::TWRAS_M_BYTE: begin
				if (tick) begin
					if (ph_reg == 2'h0) begin
						// Data set up while clock is low
						if (!ack_bit) begin
							sda_low_reg <= ~shift_reg[`TWRAS_MSB];
						end else begin
							sda_low_reg <= rd_data & ~last_bt;
						end
					end else if (ph_reg == 2'h1) begin
						scl_reg <= 1'b1;
					end else if (ph_reg == 2'h2) begin
						if (!ack_bit) begin
							shift_reg <= {shift_reg[6:0], sda_s};
						end else if (!rd_data) begin
							nack_reg <= sda_s;
						end
					end else begin
						scl_reg <= 1'b0;
						if (!ack_bit) begin
							bit_reg <= bit_reg + 4'h1;
						end else begin
							bit_reg <= 4'h0;
							if (!rd_data && nack_reg) begin
								state_reg <= twras_pkg::TWRAS_M_STOP;
							end else if (role_reg == twras_pkg::TWRAS_R_ADDRW) begin
								role_reg  <= twras_pkg::TWRAS_R_SUB;
								shift_reg <= sub_reg;
							end else if (role_reg == twras_pkg::TWRAS_R_SUB) begin
								if (rw_reg) begin
									state_reg <= twras_pkg::TWRAS_M_START;
									role_reg  <= twras_pkg::TWRAS_R_ADDRR;
								end else begin
									role_reg  <= twras_pkg::TWRAS_R_DATA;
									shift_reg <= i_wdata;
									take_reg  <= 1'b1;
								end
							end else if (role_reg == twras_pkg::TWRAS_R_ADDRR) begin
								role_reg  <= twras_pkg::TWRAS_R_DATA;
								shift_reg <= 8'hff;
							end else begin
								// One data byte done
								rdata_reg <= shift_reg;
								rvld_reg  <= rw_reg;
								left_reg  <= left_reg - 4'h1;
								if (last_bt) begin
									state_reg <= twras_pkg::TWRAS_M_STOP;
								end else begin
									shift_reg <= rw_reg ? 8'hff : i_wdata;
									take_reg  <= ~rw_reg;
								end
							end
						end
					end
				end
			end
			twras_pkg::TWRAS_M_STOP: begin
				if (tick) begin
					if (ph_reg == 2'h0) begin
						sda_low_reg <= 1'b1;
					end else if (ph_reg == 2'h1) begin
						scl_reg <= 1'b1;
					end else if (ph_reg == 2'h2) begin
						sda_low_reg <= 1'b0;
					end else begin
						state_reg <= twras_pkg::TWRAS_M_IDLE;
						done_reg  <= 1'b1;
					end
				end
			end
			default: begin
				state_reg <= twras_pkg::TWRAS_M_IDLE;
			end
			endcase
		end
	end

	// Bus drive: clock pushed, data only pulled low
	assign bus.scl      = scl_reg;
	assign bus.m_sda_o  = 1'b0;
	assign bus.m_sda_oe = sda_low_reg;

	// User side outputs
	assign o_wdata_take = take_reg;
	assign o_rdata      = rdata_reg;
	assign o_rdata_vld  = rvld_reg;
	assign o_busy       = (state_reg != twras_pkg::TWRAS_M_IDLE);
	assign o_done       = done_reg;
	assign o_nack       = nack_reg;

endmodule : twras_master

/* twras_checker.sv */
// Checker of the wired two-wire bus between master and slave
module twras_checker (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// Bus lines and drivers
	input wire logic scl,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic s_sda_o,
	input wire logic s_sda_oe,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] bit_reg;
	logic [1:0] byte_reg;
	logic       rd_reg;
	logic       nak_reg;
	logic       scl_d_reg;
	logic       sda_d_reg;
	wire        rise;
	wire        frame;
	wire        wrap;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rstn);

	// Clock rise, start or stop, end of a byte slot
	assign rise  = scl & ~scl_d_reg;
	assign frame = scl & scl_d_reg & (sda ^ sda_d_reg);
	assign wrap  = (bit_reg == 4'h9);

	// Line history, idle high in reset
	always_ff @(posedge i_mclk) begin
		scl_d_reg <= scl | ~i_rstn;
		sda_d_reg <= sda | ~i_rstn;
	end

	// Bit and byte position inside the current frame
	always_ff @(posedge i_mclk) begin
		if (!i_rstn || frame) begin
			bit_reg  <= 4'h0;
			byte_reg <= 2'h0;
			rd_reg   <= 1'b0;
			nak_reg  <= 1'b0;
		end else if (rise) begin
			bit_reg  <= wrap ? 4'h1 : bit_reg + 4'h1;
			byte_reg <= byte_reg + {1'b0, wrap && byte_reg != 2'h2};
			rd_reg   <= (byte_reg == 2'h0 && bit_reg == 4'h7) ? sda : rd_reg;
			nak_reg  <= rd_reg && byte_reg != 2'h0 && bit_reg == 4'h8 && sda;
		end
	end

	// Start and stop shapes
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence

	a_slave_moves_low: assert property (
		$changed(s_sda_oe) |-> !scl && !scl_d_reg)
		else $error("slave data changed while clock high");
	a_open_drain: assert property (
		s_sda_oe |-> !s_sda_o && !sda)
		else $error("slave pull does not hold the line low");
	a_addr_quiet: assert property (
		byte_reg == 2'h0 && bit_reg < 4'h8 |-> !s_sda_oe)
		else $error("slave drove during address bits");
	a_addr_ack: assert property (
		rise && bit_reg == 4'h8 && (byte_reg == 2'h0 ||
		(byte_reg == 2'h1 && !rd_reg)) |-> s_sda_oe && !sda)
		else $error("address or index byte not acknowledged");
	a_ack_release: assert property (
		rise && wrap && !rd_reg |-> !s_sda_oe)
		else $error("slave held the line after its acknowledge");
	a_host_quiet: assert property (
		rise && rd_reg && byte_reg != 2'h0 && bit_reg < 4'h8 |-> !m_sda_oe)
		else $error("master drove while slave sends");
	a_ack_no_clash: assert property (
		scl && s_sda_oe |-> !m_sda_oe)
		else $error("master drove during slave acknowledge");
	a_nack_release: assert property (
		rise && nak_reg |-> !s_sda_oe)
		else $error("slave kept sending after not-acknowledge");
	a_nack_stops: assert property (
		rise && bit_reg == 4'h8 && !rd_reg && sda |-> ##[1:600] s_stop)
		else $error("no stop after slave not-acknowledge");
	a_start_owner: assert property (
		s_start |-> m_sda_oe && !s_sda_oe)
		else $error("start not made by the master");
	a_stop_idle: assert property (
		s_stop |=> scl [*8])
		else $error("clock left idle level right after stop");

endmodule : twras_checker

/* tb_top.sv */
// Testbench joining the two-wire master and slave ends
`include "twras_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic        i_mclk = 1'b0;
	logic        i_lclk = 1'b0;
	logic        i_rstn = 1'b0;
	logic        go = 1'b0;
	logic        rw = 1'b0;
	logic [7:0]  sub = 8'h00;
	logic [3:0]  cnt = 4'h1;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  wbase = 8'h00;
	logic [7:0]  wtk = 8'h00;
	logic [7:0]  pops = 8'h00;
	logic [7:0]  rd_data = 8'h00;
	logic        wr_ready = 1'b1;
	logic        addr_fifo = 1'b0;
	logic [7:0]  w0, p0, rdata, s_addr, wr_data;
	logic        take, rvld, done, nack, wr_stb, wr_stb_b, rd_stb;
	logic        mbusy, sbusy;
	logic [15:0] wq[$];
	logic [7:0]  rq[$];
	int          error_cnt = 0;
	int          comparisons = 0;

	// Command clock and an unrelated link clock
	always #5 i_mclk = ~i_mclk;
	initial begin
		#3.3;
		forever #7.5 i_lclk = ~i_lclk;
	end

	twras_if bus ();
	twras_if bus_b ();

	// Master and slave joined on the first bus, fast rate
	twras_master #(.SCL_HZ(`TWRAS_SCL_FAST_HZ)) u_twras_master (
		.i_mclk(i_mclk), .i_rstn(i_rstn), .bus(bus), .i_go(go),
		.i_rw(rw), .i_sub(sub), .i_count(cnt), .i_wdata(wdata),
		.o_wdata_take(take), .o_rdata(rdata), .o_rdata_vld(rvld),
		.o_busy(mbusy), .o_done(done), .o_nack(nack));
	twras_slave u_twras_slave (
		.i_lclk(i_lclk), .i_rstn(i_rstn), .bus(bus), .o_addr(s_addr),
		.o_wr_stb(wr_stb), .o_wr_data(wr_data), .i_wr_ready(wr_ready),
		.i_addr_fifo(addr_fifo), .o_rd_stb(rd_stb), .i_rd_data(rd_data),
		.o_busy(sbusy));
	// Second slave on a bus stepped by hand
	twras_slave u_twras_slave_b (
		.i_lclk(i_lclk), .i_rstn(i_rstn), .bus(bus_b), .o_addr(),
		.o_wr_stb(wr_stb_b), .o_wr_data(), .i_wr_ready(wr_ready),
		.i_addr_fifo(addr_fifo), .o_rd_stb(), .i_rd_data(rd_data),
		.o_busy());
	twras_checker u_twras_checker (
		.i_mclk(i_mclk), .i_rstn(i_rstn), .scl(bus.scl),
		.m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe),
		.s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe), .sda(bus.sda));

	// Register side: collect writes, serve a byte per pop
	always @(posedge i_lclk) begin
		if (wr_stb === 1'b1) wq.push_back({s_addr, wr_data});
		if (wr_stb_b === 1'b1) wq.push_back(16'hffff);
		if (rd_stb === 1'b1) pops <= pops + 8'h01;
		rd_data <= (s_addr ^ 8'h5a) + pops + {7'h0, rd_stb === 1'b1};
	end

	// Command side: collect reads, next write byte after each take
	always @(posedge i_mclk) begin
		if (rvld === 1'b1) rq.push_back(rdata);
		if (take === 1'b1) wtk <= wtk + 8'h01;
		wdata <= wbase + wtk + {7'h0, take === 1'b1};
	end

	// Count a comparison and report a mismatch
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Run one master transfer and wait for its completion
	task automatic xfer(input logic r, input logic [7:0] s,
		input logic [3:0] n, input logic f, input logic rdy);
		int k;
		@(posedge i_lclk);
		addr_fifo <= f;
		wr_ready  <= rdy;
		@(posedge i_mclk);
		rw    <= r;
		sub   <= s;
		cnt   <= n;
		wbase <= s + 8'h11;
		repeat (2) @(posedge i_mclk);
		w0 = wtk;
		p0 = pops;
		wq.delete();
		rq.delete();
		go <= 1'b1;
		@(posedge i_mclk);
		go <= 1'b0;
		// Master busy at once, slave not yet reached by the start
		@(posedge i_mclk);
		chk({14'h0, mbusy, sbusy}, 16'h2);
		for (k = 0; k < 40000 && done !== 1'b1; k++) begin
			@(posedge i_mclk);
		end
		if (k == 40000) begin
			chk({15'h0, done}, 16'h1);
			print_verdict();
		end
		// Both ends idle again once the stop is through
		chk({14'h0, mbusy, sbusy}, 16'h0);
	endtask : xfer

	// Compare bytes written on the slave side and the refusal flag
	task automatic exp_wr(input logic [7:0] s, input int nw, input logic nk);
		int k;
		chk(16'(wq.size()), 16'(nw));
		for (k = 0; k < nw && k < wq.size(); k++) begin
			chk(wq[k], {s, wbase + w0 + 8'(k)});
		end
		chk({15'h0, nack}, {15'h0, nk});
	endtask : exp_wr

	// Compare bytes read back and the pops seen by the slave
	task automatic exp_rd(input logic [7:0] s, input int n);
		int k;
		chk(16'(rq.size()), 16'(n));
		chk({8'h0, pops - p0}, 16'(n));
		chk({8'h0, s_addr}, {8'h0, s});
		for (k = 0; k < n && k < rq.size(); k++) begin
			chk({8'h0, rq[k]}, {8'h0, (s ^ 8'h5a) + p0 + 8'(k)});
		end
		chk({15'h0, nack}, 16'h0);
	endtask : exp_rd

	// Single register write
	task automatic sc_reg_write();
		xfer(1'b0, 8'h12, 4'h1, 1'b0, 1'b1);
		exp_wr(8'h12, 1, 1'b0);
	endtask : sc_reg_write

	// Three bytes into a FIFO
	task automatic sc_fifo_write();
		xfer(1'b0, 8'h40, 4'h3, 1'b1, 1'b1);
		exp_wr(8'h40, 3, 1'b0);
	endtask : sc_fifo_write

	// Second byte to a register is refused and the master stops
	task automatic sc_reg_burst();
		xfer(1'b0, 8'h13, 4'h2, 1'b0, 1'b1);
		exp_wr(8'h13, 1, 1'b1);
	endtask : sc_reg_burst

	// Write side not ready: data byte refused
	task automatic sc_not_ready();
		xfer(1'b0, 8'h14, 4'h1, 1'b0, 1'b0);
		exp_wr(8'h14, 0, 1'b1);
	endtask : sc_not_ready

	// Single register read through a repeated start
	task automatic sc_reg_read();
		xfer(1'b1, 8'h21, 4'h1, 1'b0, 1'b1);
		exp_rd(8'h21, 1);
	endtask : sc_reg_read

	// Three bytes out of a FIFO
	task automatic sc_fifo_read();
		xfer(1'b1, 8'h42, 4'h3, 1'b1, 1'b1);
		exp_rd(8'h42, 3);
	endtask : sc_fifo_read

	// Step the second bus by hand: one third of a data bit
	task automatic bb(input logic c, input logic d);
		@(posedge i_mclk);
		bus_b.scl      <= c;
		bus_b.m_sda_oe <= d;
		repeat (20) @(posedge i_mclk);
	endtask : bb

	// Foreign address, then our address as plain data: both ignored
	task automatic sc_foreign();
		logic [17:0] pat;
		int k;
		pat = {8'h5e, 1'b1, 8'h5c, 1'b1};
		wq.delete();
		bb(1'b1, 1'b1);
		bb(1'b0, 1'b1);
		for (k = 0; k < 18; k++) begin
			bb(1'b0, ~pat[17-k]);
			bb(1'b1, ~pat[17-k]);
			if (k == 8 || k == 17) chk({15'h0, bus_b.sda}, 16'h1);
			bb(1'b0, ~pat[17-k]);
		end
		bb(1'b0, 1'b1);
		bb(1'b1, 1'b1);
		bb(1'b1, 1'b0);
		chk(16'(wq.size()), 16'h0);
	endtask : sc_foreign

	// Verdict and end of run
	task automatic print_verdict();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict

	// Reset, then the scenarios in turn
	initial begin
		bus_b.scl      = 1'b1;
		bus_b.m_sda_o  = 1'b0;
		bus_b.m_sda_oe = 1'b0;
		repeat (5) @(posedge i_mclk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_mclk);
		sc_reg_write();
		sc_fifo_write();
		sc_reg_burst();
		sc_not_ready();
		sc_reg_read();
		sc_fifo_read();
		sc_foreign();
		print_verdict();
	end

endmodule : tb_top
